// [rtl/dws_pkg.sv]
package dws_pkg;
    // ==========================================
    // Widths, burst length and depths
    localparam int ADDR_W   = 19;
    localparam int DATA_W   = 36;
    localparam int LANES    = 4;
    localparam int LANE_W   = 9;
    localparam int BURST_LEN = 2;
    localparam int FIFO_DEPTH = 2;
    localparam int DEPTH    = 1 << ADDR_W;
    // ==========================================
    // Reset values
    localparam logic [1:0] READS_RST = 2'h0;
    localparam logic [1:0] CNT_RST   = 2'h0;
    localparam logic       PHASE_RST = 1'b0;
endpackage

// [rtl/dws_mem_if.sv]
interface dws_mem_if;
    import dws_pkg::*;
    logic                wr_en;
    logic [LANES-1:0]    wr_lane_n;
    logic [ADDR_W-1:0]   wr_addr;
    logic [DATA_W-1:0]   wr_data;
    logic                rd_en;
    logic [ADDR_W-1:0]   rd_addr;
    logic [DATA_W-1:0]   rd_data;
    logic                rd_valid;
    modport port  (output wr_en, wr_lane_n, wr_addr, wr_data, rd_en, rd_addr,
                   input  rd_data, rd_valid);
    modport array (input  wr_en, wr_lane_n, wr_addr, wr_data, rd_en, rd_addr,
                   output rd_data, rd_valid);
endinterface

// [rtl/dws_array.sv]
module dws_array
    import dws_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    dws_mem_if.array  mem
);
    logic [DATA_W-1:0] store [DEPTH];

    // ==========================================
    // Byte-lane write
    always_ff @(posedge ref_clk) begin
        if (clk_en && mem.wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (!mem.wr_lane_n[i]) begin
                    store[mem.wr_addr][i*LANE_W +: LANE_W] <=
                        mem.wr_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ==========================================
    // Registered read
    always_ff @(posedge ref_clk) begin
        if (clk_en && mem.rd_en) begin
            mem.rd_data <= store[mem.rd_addr];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mem.rd_valid <= 1'b0;
        end else if (clk_en) begin
            mem.rd_valid <= mem.rd_en;
        end
    end
endmodule

// [rtl/dws_port.sv]
module dws_port
    import dws_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              load_n,
    input  wire logic              read_write_select,
    input  wire logic [ADDR_W-2:0] addr_hi,
    input  wire logic              burst_lsb_addr,
    input  wire logic [LANES-1:0]  byte_lane_enable_n,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic              output_strobe_p,
    input  wire logic              output_strobe_n,
    input  wire logic              single_clock_mode,
    input  wire logic              dll_off_n,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    output logic                   echo_strobe_p,
    output logic                   echo_strobe_n,
    output logic                   dll_bypass
);
    // ==========================================
    // Pin synchronisers
    localparam int SYN_W = 1 + 1 + (ADDR_W-1) + 1 + LANES + DATA_W + 4;
    logic [SYN_W-1:0] syn_a;
    logic [SYN_W-1:0] syn_b;
    logic             s_load_n;
    logic             s_rw;
    logic [ADDR_W-2:0] s_addr_hi;
    logic             s_lsb;
    logic [LANES-1:0] s_be_n;
    logic [DATA_W-1:0] s_dq;
    logic             s_cp;
    logic             s_cn;
    logic             s_single;
    logic             s_dll_n;

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            syn_a <= {load_n, read_write_select, addr_hi, burst_lsb_addr,
                      byte_lane_enable_n, dq_in, output_strobe_p, output_strobe_n,
                      single_clock_mode, dll_off_n};
            syn_b <= syn_a;
        end
    end
    assign {s_load_n, s_rw, s_addr_hi, s_lsb, s_be_n, s_dq,
            s_cp, s_cn, s_single, s_dll_n} = syn_b;

    // ==========================================
    // Edge phase: 0 is main rising edge, 1 is complement rising edge
    logic phase;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase <= PHASE_RST;
        end else if (clk_en) begin
            phase <= ~phase;
        end
    end

    logic start;
    assign start = !phase && !s_load_n;

    // ==========================================
    // Write burst
    dws_mem_if mem ();
    logic                wr_second;
    logic [ADDR_W-2:0]   wr_hi;
    logic                wr_lsb;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_second <= 1'b0;
        end else if (clk_en) begin
            wr_second <= start && !s_rw;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en && start) begin
            wr_hi  <= s_addr_hi;
            wr_lsb <= s_lsb;
        end
    end

    always_comb begin
        mem.wr_en     = clk_en && ((start && !s_rw) || wr_second);
        mem.wr_lane_n = s_be_n;
        mem.wr_data   = s_dq;
        if (wr_second) begin
            mem.wr_addr = {wr_hi, ~wr_lsb};
        end else begin
            mem.wr_addr = {s_addr_hi, s_lsb};
        end
    end

    // ==========================================
    // Read burst issue, gated by buffer space
    logic [1:0]        reads_left;
    logic [ADDR_W-2:0] rd_hi;
    logic              rd_bit;
    logic [1:0]        fifo_cnt;
    logic              fifo_in_ready;
    logic              issue;

    assign fifo_in_ready = (fifo_cnt + {1'b0, mem.rd_valid}) < 2'(FIFO_DEPTH);
    assign issue = (reads_left != READS_RST) && fifo_in_ready && !start;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reads_left <= READS_RST;
        end else if (clk_en) begin
            if (start && s_rw) begin
                reads_left <= 2'(BURST_LEN);
            end else if (issue) begin
                reads_left <= reads_left - 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (start && s_rw) begin
                rd_hi  <= s_addr_hi;
                rd_bit <= s_lsb;
            end else if (issue) begin
                rd_bit <= ~rd_bit;
            end
        end
    end

    assign mem.rd_en   = clk_en && issue;
    assign mem.rd_addr = {rd_hi, rd_bit};

    dws_array u_array (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .mem     (mem)
    );

    // ==========================================
    // Two-entry read buffer
    logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
    logic              wr_ptr;
    logic              rd_ptr;
    logic              fifo_out_valid;
    logic              launch_slot;
    logic              pop;
    logic              push;
    logic              strobe_p_d;
    logic              strobe_n_d;

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            strobe_p_d <= s_cp;
            strobe_n_d <= s_cn;
        end
    end

    // Launch slot: strobe rise, or every main/complement edge in single mode
    assign launch_slot = s_single ? 1'b1
                       : ((s_cp && !strobe_p_d) || (s_cn && !strobe_n_d));
    assign fifo_out_valid = fifo_cnt != CNT_RST;
    assign push = mem.rd_valid;
    assign pop  = fifo_out_valid && launch_slot;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fifo_cnt <= CNT_RST;
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
        end else if (clk_en) begin
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en && push) begin
            fifo_mem[wr_ptr] <= mem.rd_data;
        end
    end

    // ==========================================
    // Output drivers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe  <= 1'b0;
        end else if (clk_en) begin
            if (pop) begin
                dq_out <= fifo_mem[rd_ptr];
                dq_oe  <= 1'b1;
            end else if (launch_slot) begin
                dq_oe  <= 1'b0;
            end
        end
    end

    // ==========================================
    // Echo strobes and DLL mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            echo_strobe_p <= 1'b0;
            echo_strobe_n <= 1'b1;
            dll_bypass    <= 1'b0;
        end else if (clk_en) begin
            echo_strobe_p <= s_single ? ~phase : s_cp;
            echo_strobe_n <= s_single ? phase : s_cn;
            dll_bypass    <= ~s_dll_n;
        end
    end
endmodule

// [bench/dws_port_monitor.sv]
module dws_port_monitor
    import dws_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load_n,
    input wire logic read_write_select,
    input wire logic single_clock_mode,
    input wire logic dll_off_n,
    input wire logic dq_oe,
    input wire logic echo_strobe_p,
    input wire logic echo_strobe_n,
    input wire logic dll_bypass
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Read burst, echo, DLL and reset checks
    logic [4:0] quiet;
    logic [4:0] since_rd;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge ref_clk)
        if (!rst_n || !load_n) quiet <= 5'h0;
        else if (quiet != 5'h1F) quiet <= quiet + 5'h1;
    always_ff @(posedge ref_clk)
        if (!rst_n) since_rd <= 5'h1F;
        else if (!load_n && read_write_select) since_rd <= 5'h0;
        else if (since_rd != 5'h1F) since_rd <= since_rd + 5'h1;
    sequence s_burst;
        dq_oe ##1 !dq_oe;
    endsequence
    // Single mode held out of reset long enough for the echo to run
    sequence s_single;
        (single_clock_mode && rst_n) [*5];
    endsequence
    a_oe_span: assert property ($rose(dq_oe) |=> s_burst)
        else $error("bad burst");
    a_idle_quiet: assert property (quiet >= 5'h10 |-> !dq_oe)
        else $error("oe idle");
    a_oe_cause: assert property ($rose(dq_oe) |-> since_rd <= 5'h10)
        else $error("oe");
    a_echo_pair: assert property (echo_strobe_n == !echo_strobe_p)
        else $error("echo");
    a_echo_toggle: assert property (s_single |-> $changed(echo_strobe_p))
        else $error("echo still");
    a_dll_on: assert property (dll_off_n [*5] |-> !dll_bypass)
        else $error("dll");
    a_dll_off: assert property (!dll_off_n [*5] |-> dll_bypass)
        else $error("dll");
    a_reset_vals: assert property (disable iff (1'b0) !rst_n |=>
        !dq_oe && !echo_strobe_p && echo_strobe_n && !dll_bypass) else $error("reset");
endmodule
bind dws_port dws_port_monitor i_mon (.ref_clk, .rst_n, .load_n, .read_write_select,
    .single_clock_mode, .dll_off_n, .dq_oe, .echo_strobe_p, .echo_strobe_n, .dll_bypass);

// [bench/dws_ctrl_model.sv]
module dws_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic run,
    output logic      strobe_p,
    output wire logic strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Output strobe pair, still when idle
    initial strobe_p = 1'b0;
    always @(negedge ref_clk) strobe_p <= run ? !strobe_p : 1'b0;
    assign strobe_n = !strobe_p;
endmodule

// [bench/ddr_two_word_burst_sram_port_tb.sv]
module ddr_two_word_burst_sram_port_tb
    import dws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Stimulus and checks
`define CHK(g, e) chk(DATA_W'(g), DATA_W'(e))
    logic              ref_clk, rst_n, load_n, rw, lsb, scm, dll_off_n, run, sp, sn, ce;
    logic              dq_oe, ep, en, byp, held;
    logic [ADDR_W-2:0] addr_hi;
    logic [ADDR_W-1:0] a;
    logic [LANES-1:0]  be_n;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [31:0]       seed = 32'h11;
    logic [31:0]       cyc = 32'h0;
    int                fail_count = 0;
    int                num_checks = 0;
    dws_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce), .load_n(load_n),
        .read_write_select(rw), .addr_hi(addr_hi), .burst_lsb_addr(lsb),
        .byte_lane_enable_n(be_n), .dq_in(dq_in), .output_strobe_p(sp),
        .output_strobe_n(sn), .single_clock_mode(scm), .dll_off_n(dll_off_n),
        .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe_p(ep), .echo_strobe_n(en),
        .dll_bypass(byp));
    dws_ctrl_model i_ctrl (.ref_clk(ref_clk), .run(run), .strobe_p(sp), .strobe_n(sn));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] w, logic [3:0] b);
        logic [35:0] m;
        m = {{9{b[3]}}, {9{b[2]}}, {9{b[1]}}, {9{b[0]}}};
        return (o & m) | (w & ~m);
    endfunction
    task automatic chk(logic [35:0] g, logic [35:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic step();
        @(negedge ref_clk);
    endtask
    task automatic load(logic [18:0] ad, logic r);
        step();
        while (cyc[0]) step();
        load_n = 1'b0;
        rw = r;
        {addr_hi, lsb} = ad;
    endtask
    task automatic wr(logic [18:0] ad, logic [35:0] w0, w1, logic [3:0] b0, b1);
        load(ad, 1'b0);
        dq_in = w0;
        be_n = b0;
        step();
        load_n = 1'b1;
        dq_in = w1;
        be_n = b1;
        step();
        mem[ad] = merge(mem[ad], w0, b0);
        mem[ad ^ 19'h1] = merge(mem[ad ^ 19'h1], w1, b1);
    endtask
    task automatic rd(logic [18:0] ad);
        int n;
        load(ad, 1'b1);
        step();
        load_n = 1'b1;
        n = 0;
        while (dq_oe !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        `CHK(dq_out, mem[ad]);
        step();
        `CHK(dq_out, mem[ad ^ 19'h1]);
        step();
        `CHK(dq_oe, 1'b0);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= rst_n ? cyc + 32'h1 : 32'h0;
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    initial begin
        {rst_n, rw, lsb, addr_hi, be_n, dq_in, run} = '0;
        {ce, load_n, scm, dll_off_n} = 4'hF;
        held = 1'b0;
        repeat (10) step();
        rst_n = 1'b1;
        for (int m = 1; m >= 0; m--) begin
            scm = m[0];
            run = !m[0];
            repeat (8) step();
            for (int i = 0; i < 4; i++) begin
                a = (i == 0) ? 19'h7FFFF : 19'(rnd());
                wr(a, 36'({rnd(), rnd()}), 36'({rnd(), rnd()}), 4'h0, 4'h0);
                rd(a);
                wr(a, 36'({rnd(), rnd()}), 36'({rnd(), rnd()}),
                   (i == 0) ? 4'hE : 4'(rnd()), (i == 0) ? 4'h7 : 4'(rnd()));
                rd(a);
            end
            $display("burst test mode %0d done", m);
        end
        rw = 1'b1;
        for (int i = 0; i < 24; i++) begin
            step();
            {addr_hi, lsb} = 19'(rnd());
            load_n = !(cyc[0] && i < 8);
            `CHK(dq_oe, 1'b0);
        end
        load_n = 1'b1;
        dll_off_n = 1'b0;
        repeat (6) step();
        `CHK(byp, 1'b1);
        dll_off_n = 1'b1;
        repeat (6) step();
        `CHK(byp, 1'b0);
        $display("idle and dll tests done");
        // Clock enable low: the running echo must hold still
        ce = 1'b0;
        step();
        held = ep;
        repeat (3) step();
        `CHK(ep, held);
        ce = 1'b1;
        $display("freeze test done");
        end_sim();
    end
endmodule
